// [common/gate_drive_pkg.sv]
package gate_drive_pkg;

    // =====================================================
    // timing and derived cycle counts at 100 MHz
    // =====================================================
    localparam int CLK_PERIOD_NS = 10;
    localparam int REFRESH_NS = 500;
    localparam int REFRESH_CYCLES = (REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GLITCH_CYCLES = 8;
    localparam int BLANK_CYCLES = 100;
    localparam int READY_DELAY_CYCLES = 16;
    localparam int WATCHDOG_CYCLES = 3 * REFRESH_CYCLES;
    localparam int CLEAR_MIN_CYCLES = 50;
    localparam int CNT_W = 16;

    // =====================================================
    // synchroniser reset values (pull-down, pull-up, pull-up)
    // =====================================================
    localparam logic CMD_POS_RESET = 1'b0;
    localparam logic CMD_NEG_RESET = 1'b1;
    localparam logic ENABLE_RESET = 1'b1;

    // =====================================================
    // bundled status flags
    // =====================================================
    typedef struct packed {
        logic inLockout;
        logic outLockout;
        logic linkFault;
    } health_s;

    // output-side state
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_BLANK = 2'b01,
        ST_ON = 2'b10,
        ST_FAULT = 2'b11
    } drive_state_e;

endpackage

// [rtl/glitch_filter.sv]
`timescale 1ns/1ns
`default_nettype none

module glitch_filter #(
    parameter int DEPTH = 8,
    parameter logic INIT = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // raw asynchronous level and its filtered copy
    input wire logic rawIn,
    output logic filtOut
);

    logic syncA_reg;
    logic syncB_reg;
    logic [15:0] runCnt_reg;

    // two-stage synchroniser
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            syncA_reg <= INIT;
            syncB_reg <= INIT;
        end
        else
        begin
            syncA_reg <= rawIn;
            syncB_reg <= syncA_reg;
        end
    end

    // output changes only after DEPTH steady cycles
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            runCnt_reg <= 16'h0000;
            filtOut <= INIT;
        end
        else if (syncB_reg == filtOut)
        begin
            runCnt_reg <= 16'h0000;
        end
        else if (runCnt_reg >= 16'(DEPTH - 1))
        begin
            runCnt_reg <= 16'h0000;
            filtOut <= syncB_reg;
        end
        else
        begin
            runCnt_reg <= runCnt_reg + 16'h0001;
        end
    end

endmodule

`default_nettype wire

// [rtl/isolated_gate_drive_control.sv]
// Contract
// - gate is on only for positive command high, negative command low, enable high.
// - command pulses shorter than the minimum width never change the gate.
// - undriven positive command reads low and negative command reads high.
// - input-side lockout sends off, forces gate off and ignores commands.
// - output-side lockout forces gate off and ignores incoming commands.
// - health is high only with no lockout and a sound link; output lockout is delayed.
// - health never latches and needs no clearing.
// - the input side resends the current command every 500 ns.
// - a watchdog forces gate off and drops health when resends stop arriving.
// - a saturation event while on and past blanking forces off and sets the fault.
// - saturation is judged only after a blanking interval from turn-on.
// - the fault output is active-low open drain and holds until cleared.
// - the fault clears on enable rising only after a long enough low time.
// - holding enable low shuts the input logic and keeps the gate off.
// - the sink clamp turns on when the gate falls near the negative rail while off.
`timescale 1ns/1ns
`default_nettype none

module isolated_gate_drive_control #(
    parameter int GLITCH_CYCLES = gate_drive_pkg::GLITCH_CYCLES,
    parameter int BLANK_CYCLES = gate_drive_pkg::BLANK_CYCLES,
    parameter int READY_DELAY_CYCLES = gate_drive_pkg::READY_DELAY_CYCLES,
    parameter int REFRESH_CYCLES = gate_drive_pkg::REFRESH_CYCLES,
    parameter int WATCHDOG_CYCLES = gate_drive_pkg::WATCHDOG_CYCLES,
    parameter int CLEAR_MIN_CYCLES = gate_drive_pkg::CLEAR_MIN_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // controller command pins
    input wire logic cmdPos,
    input wire logic cmdNeg,
    input wire logic enable_n,
    // analog comparator levels
    input wire logic inSupplyLockout,
    input wire logic outSupplyLockout,
    input wire logic satSenseHigh,
    input wire logic gateNearRail,
    // link fault injection (link path break)
    input wire logic linkBreak,
    // gate stage controls
    output logic gateOn,
    output logic clampOn,
    // open-drain status pins
    output logic desatFault_n,
    output logic desatFaultOe,
    output logic ready,
    output logic readyOe
);

    localparam int W = gate_drive_pkg::CNT_W;

    logic posF, negF, enF;
    logic inLockA_reg, inLock_reg, outLockA_reg, outLock_reg;
    logic satA_reg, sat_reg, railA_reg, rail_reg;
    logic cmdWanted;
    logic [W-1:0] refreshCnt_reg;
    logic linkStrobe_reg, linkData_reg;
    logic rxCmd_reg;
    logic [W-1:0] wdCnt_reg;
    logic linkFault;
    logic [W-1:0] rdyDelay_reg;
    logic outLockDelayed;
    gate_drive_pkg::health_s health;
    gate_drive_pkg::drive_state_e state_reg;
    logic [W-1:0] blankCnt_reg;
    logic faultLatch_reg;
    logic [W-1:0] lowCnt_reg;
    logic enPrev_reg;
    logic clearPulse;
    logic forceOff;

    // =====================================================
    // input conditioning
    // =====================================================
    glitch_filter #(.DEPTH(GLITCH_CYCLES), .INIT(gate_drive_pkg::CMD_POS_RESET)) posFilt (
        .clk(clk), .rst_n(rst_n), .rawIn(cmdPos), .filtOut(posF));
    glitch_filter #(.DEPTH(GLITCH_CYCLES), .INIT(gate_drive_pkg::CMD_NEG_RESET)) negFilt (
        .clk(clk), .rst_n(rst_n), .rawIn(cmdNeg), .filtOut(negF));
    glitch_filter #(.DEPTH(GLITCH_CYCLES), .INIT(gate_drive_pkg::ENABLE_RESET)) enFilt (
        .clk(clk), .rst_n(rst_n), .rawIn(enable_n), .filtOut(enF));

    // two-flop synchronisers for comparator levels
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            inLockA_reg <= 1'b1;
            inLock_reg <= 1'b1;
            outLockA_reg <= 1'b1;
            outLock_reg <= 1'b1;
            satA_reg <= 1'b0;
            sat_reg <= 1'b0;
            railA_reg <= 1'b0;
            rail_reg <= 1'b0;
        end
        else
        begin
            inLockA_reg <= inSupplyLockout;
            inLock_reg <= inLockA_reg;
            outLockA_reg <= outSupplyLockout;
            outLock_reg <= outLockA_reg;
            satA_reg <= satSenseHigh;
            sat_reg <= satA_reg;
            railA_reg <= gateNearRail;
            rail_reg <= railA_reg;
        end
    end

    // =====================================================
    // input side: command decode and periodic resend
    // =====================================================
    // lockout or enable low force an off command onto the link
    assign cmdWanted = posF && !negF && enF && !inLock_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            refreshCnt_reg <= '0;
            linkStrobe_reg <= 1'b0;
            linkData_reg <= 1'b0;
        end
        else
        begin
            linkStrobe_reg <= 1'b0;
            if (refreshCnt_reg >= W'(REFRESH_CYCLES - 1) || cmdWanted != linkData_reg)
            begin
                refreshCnt_reg <= '0;
                linkStrobe_reg <= !linkBreak;
                linkData_reg <= cmdWanted;
            end
            else
            begin
                refreshCnt_reg <= refreshCnt_reg + 1'b1;
            end
        end
    end

    // =====================================================
    // output side: receive, watchdog, lockout delay
    // =====================================================
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rxCmd_reg <= 1'b0;
            wdCnt_reg <= '0;
        end
        else if (linkStrobe_reg)
        begin
            rxCmd_reg <= linkData_reg && !outLock_reg;
            wdCnt_reg <= '0;
        end
        else
        begin
            if (outLock_reg)
            begin
                rxCmd_reg <= 1'b0;
            end
            if (!linkFault)
            begin
                wdCnt_reg <= wdCnt_reg + 1'b1;
            end
        end
    end

    assign linkFault = wdCnt_reg >= W'(WATCHDOG_CYCLES);

    // output lockout reaches health only after a delay
    always_ff @(posedge clk)
    begin
        if (!rst_n || !outLock_reg)
        begin
            rdyDelay_reg <= '0;
        end
        else if (!outLockDelayed)
        begin
            rdyDelay_reg <= rdyDelay_reg + 1'b1;
        end
    end

    assign outLockDelayed = rdyDelay_reg >= W'(READY_DELAY_CYCLES);
    assign health = '{inLockout: inLock_reg, outLockout: outLockDelayed, linkFault: linkFault};

    // =====================================================
    // gate state machine with blanking and saturation check
    // =====================================================
    assign forceOff = !rxCmd_reg || outLock_reg || linkFault || faultLatch_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= gate_drive_pkg::ST_OFF;
            blankCnt_reg <= '0;
        end
        else
        begin
            case (state_reg)
                gate_drive_pkg::ST_OFF:
                begin
                    blankCnt_reg <= '0;
                    if (!forceOff)
                    begin
                        state_reg <= gate_drive_pkg::ST_BLANK;
                    end
                end
                gate_drive_pkg::ST_BLANK:
                begin
                    blankCnt_reg <= blankCnt_reg + 1'b1;
                    if (forceOff)
                    begin
                        state_reg <= gate_drive_pkg::ST_OFF;
                    end
                    else if (blankCnt_reg >= W'(BLANK_CYCLES - 1))
                    begin
                        state_reg <= gate_drive_pkg::ST_ON;
                    end
                end
                gate_drive_pkg::ST_ON:
                begin
                    if (sat_reg)
                    begin
                        state_reg <= gate_drive_pkg::ST_FAULT;
                    end
                    else if (forceOff)
                    begin
                        state_reg <= gate_drive_pkg::ST_OFF;
                    end
                end
                gate_drive_pkg::ST_FAULT:
                begin
                    if (!faultLatch_reg)
                    begin
                        state_reg <= gate_drive_pkg::ST_OFF;
                    end
                end
                default:
                begin
                    state_reg <= gate_drive_pkg::ST_OFF;
                end
            endcase
        end
    end

    // =====================================================
    // fault latch and qualified clear
    // =====================================================
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            enPrev_reg <= gate_drive_pkg::ENABLE_RESET;
            lowCnt_reg <= '0;
        end
        else
        begin
            enPrev_reg <= enF;
            if (enF)
            begin
                lowCnt_reg <= '0;
            end
            else if (lowCnt_reg < W'(CLEAR_MIN_CYCLES))
            begin
                lowCnt_reg <= lowCnt_reg + 1'b1;
            end
        end
    end

    assign clearPulse = enF && !enPrev_reg && lowCnt_reg >= W'(CLEAR_MIN_CYCLES);

    // set wins over clear
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            faultLatch_reg <= 1'b0;
        end
        else if (state_reg == gate_drive_pkg::ST_ON && sat_reg)
        begin
            faultLatch_reg <= 1'b1;
        end
        else if (clearPulse)
        begin
            faultLatch_reg <= 1'b0;
        end
    end

    // =====================================================
    // outputs
    // =====================================================
    assign gateOn = (state_reg == gate_drive_pkg::ST_BLANK || state_reg == gate_drive_pkg::ST_ON)
        && !forceOff && !(state_reg == gate_drive_pkg::ST_ON && sat_reg);
    assign clampOn = !gateOn && rail_reg;
    assign desatFault_n = !faultLatch_reg;
    assign desatFaultOe = faultLatch_reg; // pulled low only
    assign ready = !(health.inLockout || health.outLockout || health.linkFault);
    assign readyOe = !ready;

    // =====================================================
    // checks
    // =====================================================
    chk_gate_needs_cmd: assert property (@(posedge clk) disable iff (!rst_n)
        gateOn |-> rxCmd_reg && !faultLatch_reg)
        else $error("gate on without a valid command");
    chk_lockout_forces_off: assert property (@(posedge clk) disable iff (!rst_n)
        outLock_reg |-> !gateOn)
        else $error("gate on during output lockout");
    chk_in_lock_off: assert property (@(posedge clk) disable iff (!rst_n)
        inLock_reg [*3] |-> !cmdWanted ##1 !linkData_reg)
        else $error("command sent during input lockout");
    chk_refresh_period: assert property (@(posedge clk) disable iff (!rst_n)
        linkStrobe_reg && !linkBreak |-> ##[1:50] (linkStrobe_reg || linkBreak))
        else $error("command resend missing");
    chk_watchdog_off: assert property (@(posedge clk) disable iff (!rst_n)
        linkFault |-> !gateOn && !ready)
        else $error("watchdog fault not acted on");
    chk_fault_holds: assert property (@(posedge clk) disable iff (!rst_n)
        faultLatch_reg && !clearPulse |=> faultLatch_reg)
        else $error("fault dropped without clear");
    chk_fault_sets: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == gate_drive_pkg::ST_ON && sat_reg |=> !desatFault_n && !gateOn)
        else $error("saturation not latched");
    chk_blank_no_fault: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == gate_drive_pkg::ST_BLANK && !faultLatch_reg |=> !$rose(faultLatch_reg))
        else $error("fault during blanking");
    chk_short_low_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(enF) && lowCnt_reg < W'(CLEAR_MIN_CYCLES) && faultLatch_reg |=> faultLatch_reg)
        else $error("short enable pulse cleared fault");
    chk_enable_off: assert property (@(posedge clk) disable iff (!rst_n)
        !enF |-> !cmdWanted)
        else $error("command while disabled");
    chk_clamp_off_gate: assert property (@(posedge clk) disable iff (!rst_n)
        clampOn |-> !gateOn)
        else $error("clamp with gate on");
    chk_ready_delay: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(outLock_reg) |-> !outLockDelayed)
        else $error("output lockout reached health too early");

endmodule

`default_nettype wire

// [verification/ctrl_model.sv]
`timescale 1ns/1ns
`default_nettype none

module ctrl_model (
    // requested behaviour
    input wire logic demand,
    input wire logic invMode,
    input wire logic shutDown,
    input wire logic released,
    // raw override for illegal or glitch patterns
    input wire logic rawMode,
    input wire logic [2:0] rawPins,
    // command pins toward the driver
    output logic cmdPos,
    output logic cmdNeg,
    output logic enable_n
);

    // =====================================================
    // pin levels
    // =====================================================
    // released pins sit at their pull levels
    always_comb
    begin
        if (rawMode)
        begin
            {cmdPos, cmdNeg, enable_n} = rawPins;
        end
        else if (released)
        begin
            cmdPos = 1'b0;
            cmdNeg = 1'b1;
            enable_n = 1'b1;
        end
        else
        begin
            cmdPos = invMode | demand;
            cmdNeg = invMode & ~demand;
            enable_n = ~shutDown;
        end
    end

endmodule

`default_nettype wire

// [verification/tb_isolated_gate_drive_control.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_isolated_gate_drive_control;

    // =====================================================
    // stimulus, pins and counters
    // =====================================================
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic demand = 1'b0;
    logic invMode = 1'b0;
    logic shutDown = 1'b0;
    logic released = 1'b0;
    logic rawMode = 1'b0;
    logic [2:0] rawPins = 3'h0;
    logic inSupplyLockout = 1'b0;
    logic outSupplyLockout = 1'b0;
    logic satSenseHigh = 1'b0;
    logic gateNearRail = 1'b0;
    logic linkBreak = 1'b0;
    logic cmdPos, cmdNeg, enable_n;
    logic gateOn, clampOn, desatFault_n, desatFaultOe, ready, readyOe;
    int fail_count = 0;
    int total_checks = 0;
    int seed = 49;
    int expOn;

    // 100 MHz clock
    initial
    begin
        forever #5 clk = ~clk;
    end

    // =====================================================
    // design and controller
    // =====================================================
    // short counts keep the run brief
    isolated_gate_drive_control #(
        .GLITCH_CYCLES(2),
        .BLANK_CYCLES(4),
        .REFRESH_CYCLES(10),
        .WATCHDOG_CYCLES(30),
        .CLEAR_MIN_CYCLES(5)
    ) isolated_gate_drive_control_i (
        .clk(clk), .rst_n(rst_n), .cmdPos(cmdPos), .cmdNeg(cmdNeg), .enable_n(enable_n),
        .inSupplyLockout(inSupplyLockout), .outSupplyLockout(outSupplyLockout),
        .satSenseHigh(satSenseHigh), .gateNearRail(gateNearRail), .linkBreak(linkBreak),
        .gateOn(gateOn), .clampOn(clampOn), .desatFault_n(desatFault_n),
        .desatFaultOe(desatFaultOe), .ready(ready), .readyOe(readyOe)
    );

    ctrl_model ctrl_model_i (
        .demand(demand), .invMode(invMode), .shutDown(shutDown), .released(released),
        .rawMode(rawMode), .rawPins(rawPins),
        .cmdPos(cmdPos), .cmdNeg(cmdNeg), .enable_n(enable_n)
    );

    // =====================================================
    // checking helpers
    // =====================================================
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t got %b expected %b", $time, got, exp);
        end
    endtask

    // output by index: gate, clamp, fault, health
    function automatic logic pick(input int sel);
        case (sel)
            0: return gateOn;
            1: return clampOn;
            2: return desatFault_n;
            default: return ready;
        endcase
    endfunction

    // bounded wait, a run-out ends the test
    task automatic waitSig(input int sel, input logic exp, input int bound);
        int n;
        n = 0;
        while (pick(sel) !== exp && n < bound)
        begin
            @(negedge clk);
            n++;
        end
        chk(pick(sel), exp);
        if (sel == 3)
        begin
            chk(readyOe, ~exp);
        end
        if (pick(sel) !== exp)
        begin
            $display("BAD %0t wait on output %0d ran out", $time, sel);
            end_of_test();
        end
    endtask

    task automatic holdSig(input int sel, input logic exp, input int cycles);
        repeat (cycles)
        begin
            @(negedge clk);
            chk(pick(sel), exp);
        end
    endtask

    // =====================================================
    // main sequence
    // =====================================================
    initial
    begin
        repeat (10) @(negedge clk);
        chk(gateOn, 1'b0);
        chk(desatFault_n, 1'b1);
        rst_n = 1'b1;
        waitSig(3, 1'b1, 60);
        // every pin combination, raw
        rawMode = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            rawPins = i[2:0];
            expOn = (i / 4) * (1 - (i / 2) % 2) * (i % 2);
            waitSig(0, expOn[0], 40);
            holdSig(0, expOn[0], 5);
        end
        // one-cycle on pulse must be filtered
        rawMode = 1'b0;
        holdSig(0, 1'b0, 10);
        rawPins = 3'h5;
        rawMode = 1'b1;
        @(negedge clk);
        rawMode = 1'b0;
        holdSig(0, 1'b0, 20);
        // random demand in both modes
        for (int i = 0; i < 8; i++)
        begin
            invMode = 1'($random(seed));
            demand = 1'($random(seed));
            waitSig(0, demand, 40);
            holdSig(0, demand, 3 + ($unsigned($random(seed)) % 8));
        end
        // resends keep the link watchdog quiet
        invMode = 1'b0;
        demand = 1'b1;
        waitSig(0, 1'b1, 40);
        holdSig(0, 1'b1, 100);
        holdSig(3, 1'b1, 5);
        linkBreak = 1'b1;
        waitSig(0, 1'b0, 60);
        waitSig(3, 1'b0, 10);
        linkBreak = 1'b0;
        waitSig(3, 1'b1, 60);
        waitSig(0, 1'b1, 40);
        // input-side lockout ignores commands
        inSupplyLockout = 1'b1;
        waitSig(0, 1'b0, 10);
        waitSig(3, 1'b0, 10);
        demand = 1'b0;
        repeat (10) @(negedge clk);
        demand = 1'b1;
        holdSig(0, 1'b0, 20);
        inSupplyLockout = 1'b0;
        waitSig(3, 1'b1, 60);
        waitSig(0, 1'b1, 40);
        // output-side lockout, health follows later
        outSupplyLockout = 1'b1;
        waitSig(0, 1'b0, 6);
        chk(ready, 1'b1);
        waitSig(3, 1'b0, 20);
        holdSig(0, 1'b0, 10);
        outSupplyLockout = 1'b0;
        waitSig(3, 1'b1, 60);
        waitSig(0, 1'b1, 40);
        // saturation while off is ignored
        demand = 1'b0;
        waitSig(0, 1'b0, 40);
        satSenseHigh = 1'b1;
        holdSig(2, 1'b1, 10);
        demand = 1'b1;
        waitSig(0, 1'b1, 40);
        holdSig(2, 1'b1, 2);
        waitSig(2, 1'b0, 20);
        chk(gateOn, 1'b0);
        chk(desatFaultOe, 1'b1);
        satSenseHigh = 1'b0;
        holdSig(2, 1'b0, 20);
        chk(gateOn, 1'b0);
        // short enable pulse keeps the fault
        shutDown = 1'b1;
        repeat (3) @(negedge clk);
        shutDown = 1'b0;
        holdSig(2, 1'b0, 20);
        // long enable pulse clears on release
        shutDown = 1'b1;
        holdSig(2, 1'b0, 15);
        shutDown = 1'b0;
        waitSig(2, 1'b1, 20);
        chk(desatFaultOe, 1'b0);
        waitSig(0, 1'b1, 40);
        // sink clamp only while off
        demand = 1'b0;
        waitSig(0, 1'b0, 40);
        gateNearRail = 1'b1;
        waitSig(1, 1'b1, 20);
        demand = 1'b1;
        waitSig(1, 1'b0, 40);
        gateNearRail = 1'b0;
        // floating pins keep the gate off
        released = 1'b1;
        waitSig(0, 1'b0, 40);
        holdSig(0, 1'b0, 10);
        end_of_test();
    end

endmodule

`default_nettype wire
